// ### rtl/dcsw_core.v
// Contract
// R01 - Active command word is read-only, taken from network, application or keypad.
// R02 - Network source: quickstop, voltage, switch-on bits ANDed with application word.
// R03 - Network source: external fault bit ORed with application word's.
// R04 - Application source: application word used unchanged.
// R05 - Keypad source: quickstop, voltage, fault, switch-on bits from application word.
// R06 - Bit 0 one requests switch-on; zero means shutdown.
// R07 - Bit 1 zero is coast stop, removing output voltage.
// R08 - Bit 2 zero is emergency quick stop.
// R09 - Bit 3 requests run; bit 12 jog, bit 13 reverse while running.
// R10 - Controller writes bits 4, 5, 6 as one; reserved ramp controls.
// R11 - Trips reset only on rising edge of bit 7.
// R12 - Bit 8 one is an active external trip.
// R13 - Bit 10 one selects network command word source; keypad mode ignores it and keeps the keypad source.
// R14 - Bit 11 one selects network speed reference.
// R15 - Bit 14 permits switch-on-disabled to ready regardless of switch-on.
// R16 - Bit 15 requires run rising edge to enable operation.
// R17 - Status always provided; bit 0 initialised, bit 1 switched on or enabled.
// R18 - Bits 2 running, 3 fault, 4 supply, 5 low during quickstop.
// R19 - Status bit 6 set exactly in switch-on-disabled state.
// R20 - Status bit 9 set when network command is active source.
// R21 - Bits 12 jog, 13 reverse, 14 network reference flags.
// R22 - Status bit 15 set while stopping.
// R23 - State reported as 3-bit code 0 to 7.
// R24 - Faulted leaves to switch-on-disabled only on reset with no faults.
// R25 - Unused status bits 7, 8, 10, 11 read zero; command bit 9 ignored.
//
// Command word selection, status word composition and the tracking of the
// sequencer state code. Inputs come from logic on clk; the ramp datapath
// reports stop completion through stopDone.
`timescale 1ns/1ps
`include "dcsw_defines.vh"

module dcsw_core (
	clk,
	sys_rst,
	netCmdWord,
	appCmdWord,
	keypadCmdWord,
	channelSel,
	initDone,
	configMode,
	lineSupplyOk,
	faultActive,
	stopDone,
	activeCmdWord,
	statusWord,
	seqState,
	runFlag,
	jogFlag,
	reverseFlag,
	netRefFlag,
	faultResetPulse
);
	input  wire        clk;
	input  wire        sys_rst;
	input  wire [15:0] netCmdWord;
	input  wire [15:0] appCmdWord;
	input  wire [15:0] keypadCmdWord;
	input  wire [1:0]  channelSel;
	input  wire        initDone;
	input  wire        configMode;
	input  wire        lineSupplyOk;
	input  wire        faultActive;
	input  wire        stopDone;
	output wire [15:0] activeCmdWord;
	output wire [15:0] statusWord;
	output wire [2:0]  seqState;
	output wire        runFlag;
	output wire        jogFlag;
	output wire        reverseFlag;
	output wire        netRefFlag;
	output wire        faultResetPulse;

	// One-hot states, encoded to the reported code at the output
	localparam S_NOTRDY = 8'h01;
	localparam S_SOD    = 8'h02;
	localparam S_READY  = 8'h04;
	localparam S_ON     = 8'h08;
	localparam S_OPEN   = 8'h10;
	localparam S_QSTOP  = 8'h20;
	localparam S_FREACT = 8'h40;
	localparam S_FAULT  = 8'h80;

	reg [15:0] cmd_ff;
	reg [15:0] nxt_cmd;
	reg [15:0] status_ff;
	reg [15:0] nxt_status;
	reg [7:0]  state_ff;
	reg [7:0]  nxt_state;
	reg [2:0]  code_ff;
	reg [2:0]  nxt_code;
	reg        prevReset_ff;
	reg        prevRun_ff;
	reg        resetPulse_ff;
	reg        stopping_ff;
	reg        nxt_stopping;
	reg        runFlag_ff;
	reg        jogFlag_ff;
	reg        reverseFlag_ff;
	reg        netRefFlag_ff;

	wire [15:0] keepMask;
	wire        swOn;
	wire        voltOn;
	wire        qsOff;
	wire        runReq;
	wire        extFault;
	wire        anyFault;
	wire        runOk;
	wire        resetEdge;
	wire [15:0] netMerged;
	wire        useNet;
	wire [1:0]  effSel;

	// Bits the application word always owns in keypad mode
	assign keepMask = (16'h0001 << `DCSW_C_SWON) | (16'h0001 << `DCSW_C_VOLT)
		| (16'h0001 << `DCSW_C_QSTOP) | (16'h0001 << `DCSW_C_EXTF);

	// Merged per bit so the network can never override a wired stop
	genvar gi;
	generate
		for (gi = 0; gi < `DCSW_W; gi = gi + 1) begin : g_merge
			if (gi == `DCSW_C_SWON || gi == `DCSW_C_VOLT || gi == `DCSW_C_QSTOP) begin : g_and
				assign netMerged[gi] = netCmdWord[gi] & appCmdWord[gi]; // R02
			end else if (gi == `DCSW_C_EXTF) begin : g_or
				assign netMerged[gi] = netCmdWord[gi] | appCmdWord[gi]; // R03
			end else begin : g_pass
				assign netMerged[gi] = netCmdWord[gi];
			end
		end
	endgenerate

	// Application word may hand sequencing to the network; keypad keeps it
	assign useNet = channelSel == `DCSW_CH_NET
		|| (channelSel != `DCSW_CH_LOCAL && appCmdWord[`DCSW_C_USENET]); // R13
	assign effSel = useNet ? `DCSW_CH_NET : channelSel; // R13

	always @* begin
		nxt_cmd = appCmdWord; // R04
		case (effSel)
			`DCSW_CH_NET: begin
				nxt_cmd = netMerged; // R01 R02 R03
			end
			`DCSW_CH_APP: begin
				nxt_cmd = appCmdWord; // R04
			end
			`DCSW_CH_LOCAL: begin
				nxt_cmd = (keypadCmdWord & ~keepMask) | (appCmdWord & keepMask); // R05
			end
			default: begin
				nxt_cmd = appCmdWord;
			end
		endcase
	end

	// Decoded request levels; bits 4 to 6 and 9 are never looked at
	assign swOn      = cmd_ff[`DCSW_C_SWON];   // R06 R10 R25
	assign voltOn    = cmd_ff[`DCSW_C_VOLT];   // R07
	assign qsOff     = cmd_ff[`DCSW_C_QSTOP];  // R08
	assign runReq    = cmd_ff[`DCSW_C_RUN];    // R09
	assign extFault  = cmd_ff[`DCSW_C_EXTF];   // R12
	assign anyFault  = faultActive | extFault;
	assign resetEdge = cmd_ff[`DCSW_C_RFAULT] & ~prevReset_ff; // R11
	// Edge mode stops a held run level from restarting the motor
	assign runOk     = cmd_ff[`DCSW_C_EDGERUN] ? (runReq & ~prevRun_ff) : runReq; // R16

	always @* begin
		nxt_state = state_ff;
		if (anyFault && state_ff != S_FREACT && state_ff != S_FAULT && state_ff != S_NOTRDY) begin
			nxt_state = S_FREACT;
		end else begin
			case (state_ff)
				S_NOTRDY: begin
					if (initDone && !configMode) begin
						nxt_state = S_SOD;
					end
				end
				S_SOD: begin
					// Auto initialise skips the shutdown request
					if (voltOn && qsOff && (!swOn || cmd_ff[`DCSW_C_AUTOINIT])) begin
						nxt_state = S_READY; // R15
					end
				end
				S_READY: begin
					if (!voltOn || !qsOff) begin
						nxt_state = S_SOD;
					end else if (swOn) begin
						nxt_state = S_ON;
					end
				end
				S_ON: begin
					if (!voltOn || !qsOff) begin
						nxt_state = S_SOD;
					end else if (!swOn) begin
						nxt_state = S_READY;
					end else if (runOk) begin
						nxt_state = S_OPEN; // R16
					end
				end
				S_OPEN: begin
					if (!voltOn) begin
						nxt_state = S_SOD; // R07
					end else if (!qsOff) begin
						nxt_state = S_QSTOP; // R08
					end else if (!swOn && stopDone) begin
						nxt_state = S_READY; // R06
					end else if (!runReq && stopDone) begin
						nxt_state = S_ON;
					end
				end
				S_QSTOP: begin
					if (stopDone || !voltOn) begin
						nxt_state = S_SOD;
					end
				end
				S_FREACT: begin
					if (stopDone || !voltOn) begin
						nxt_state = S_FAULT;
					end
				end
				S_FAULT: begin
					// A held reset level cannot clear a fresh trip
					if (resetEdge && !anyFault) begin
						nxt_state = S_SOD; // R24
					end
				end
				default: begin
					nxt_state = S_NOTRDY;
				end
			endcase
		end
	end

	always @* begin
		case (nxt_state)
			S_NOTRDY: nxt_code = `DCSW_ST_NOTRDY; // R23
			S_SOD:    nxt_code = `DCSW_ST_SOD;
			S_READY:  nxt_code = `DCSW_ST_READY;
			S_ON:     nxt_code = `DCSW_ST_ON;
			S_OPEN:   nxt_code = `DCSW_ST_OPEN;
			S_QSTOP:  nxt_code = `DCSW_ST_QSTOP;
			S_FREACT: nxt_code = `DCSW_ST_FREACT;
			S_FAULT:  nxt_code = `DCSW_ST_FAULT;
			default:  nxt_code = `DCSW_ST_NOTRDY;
		endcase
	end

	always @* begin
		nxt_stopping = (state_ff == S_OPEN && (!runReq || !swOn)) || state_ff == S_QSTOP;
		nxt_status = `DCSW_ZERO16; // R25
		nxt_status[`DCSW_S_RDY]      = state_ff != S_NOTRDY && !configMode; // R17
		nxt_status[`DCSW_S_ON]       = state_ff == S_ON || state_ff == S_OPEN; // R17
		nxt_status[`DCSW_S_OPEN]     = state_ff == S_OPEN; // R18
		nxt_status[`DCSW_S_FLT]      = state_ff == S_FREACT || state_ff == S_FAULT; // R18
		nxt_status[`DCSW_S_VOLT]     = lineSupplyOk; // R18
		nxt_status[`DCSW_S_QSINACT]  = state_ff != S_QSTOP; // R18
		nxt_status[`DCSW_S_SOD]      = state_ff == S_SOD; // R19
		nxt_status[`DCSW_S_NET]      = useNet; // R20
		nxt_status[`DCSW_S_JOG]      = cmd_ff[`DCSW_C_JOG]; // R21
		nxt_status[`DCSW_S_REV]      = cmd_ff[`DCSW_C_REV]; // R21
		nxt_status[`DCSW_S_NETREF]   = cmd_ff[`DCSW_C_NETREF]; // R21 R14
		nxt_status[`DCSW_S_STOPPING] = nxt_stopping; // R22
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			cmd_ff        <= `DCSW_ZERO16;
			status_ff     <= `DCSW_ZERO16;
			state_ff      <= S_NOTRDY;
			code_ff       <= `DCSW_ST_NOTRDY;
			prevReset_ff  <= 1'b0;
			prevRun_ff    <= 1'b0;
			resetPulse_ff <= 1'b0;
			stopping_ff   <= 1'b0;
			runFlag_ff     <= 1'b0;
			jogFlag_ff     <= 1'b0;
			reverseFlag_ff <= 1'b0;
			netRefFlag_ff  <= 1'b0;
		end else begin
			cmd_ff        <= nxt_cmd;
			status_ff     <= nxt_status;
			state_ff      <= nxt_state;
			code_ff       <= nxt_code;
			prevReset_ff  <= cmd_ff[`DCSW_C_RFAULT];
			prevRun_ff    <= runReq;
			resetPulse_ff <= resetEdge; // R11
			stopping_ff   <= nxt_stopping;
			// Flags registered from next values so the run flag moves with the state and the others with the command word
			runFlag_ff     <= nxt_state == S_OPEN && !nxt_stopping; // R09
			jogFlag_ff     <= nxt_cmd[`DCSW_C_RUN] & nxt_cmd[`DCSW_C_JOG]; // R09
			reverseFlag_ff <= nxt_cmd[`DCSW_C_RUN] & nxt_cmd[`DCSW_C_REV]; // R09
			netRefFlag_ff  <= nxt_cmd[`DCSW_C_NETREF]; // R14
		end
	end

	// Read-only view; nothing here writes the command word back
	assign activeCmdWord   = cmd_ff; // R01
	assign statusWord      = status_ff;
	assign seqState        = code_ff;
	assign runFlag         = runFlag_ff; // R09
	assign jogFlag         = jogFlag_ff; // R09
	assign reverseFlag     = reverseFlag_ff; // R09
	assign netRefFlag      = netRefFlag_ff; // R14
	assign faultResetPulse = resetPulse_ff;
endmodule // dcsw_core

// ### rtl/dcsw_defines.vh
// Constants for the drive command and status word block.
// Assumes inclusion by bare name from design files.
`ifndef DCSW_DEFINES_VH
`define DCSW_DEFINES_VH
`define DCSW_W            16
// Command word bit positions
`define DCSW_C_SWON       0
`define DCSW_C_VOLT       1
`define DCSW_C_QSTOP      2
`define DCSW_C_RUN        3
`define DCSW_C_RFAULT     7
`define DCSW_C_EXTF       8
`define DCSW_C_USENET     10
`define DCSW_C_NETREF     11
`define DCSW_C_JOG        12
`define DCSW_C_REV        13
`define DCSW_C_AUTOINIT   14
`define DCSW_C_EDGERUN    15
// Status word bit positions
`define DCSW_S_RDY        0
`define DCSW_S_ON         1
`define DCSW_S_OPEN       2
`define DCSW_S_FLT        3
`define DCSW_S_VOLT       4
`define DCSW_S_QSINACT    5
`define DCSW_S_SOD        6
`define DCSW_S_NET        9
`define DCSW_S_JOG        12
`define DCSW_S_REV        13
`define DCSW_S_NETREF     14
`define DCSW_S_STOPPING   15
// Channel select codes
`define DCSW_CH_NET       2'h0
`define DCSW_CH_APP       2'h1
`define DCSW_CH_LOCAL     2'h2
// Sequencer state codes
`define DCSW_ST_NOTRDY    3'h0
`define DCSW_ST_SOD       3'h1
`define DCSW_ST_READY     3'h2
`define DCSW_ST_ON        3'h3
`define DCSW_ST_OPEN      3'h4
`define DCSW_ST_QSTOP     3'h5
`define DCSW_ST_FREACT    3'h6
`define DCSW_ST_FAULT     3'h7
`define DCSW_ZERO16       16'h0000
`endif

// ### verif/dcsw_plc_model.sv
// Supervising controller model driving the network word.
// Assumes the bench supplies the requested command bits.
`timescale 1ns/1ps
module dcsw_plc_model (
	input	wire [15:0]	cmdReq,
	output	wire [15:0]	netCmdWord
);
	// Ramp bits held high, reserved for later use
	assign netCmdWord = cmdReq | 16'h0070;
endmodule // dcsw_plc_model

// ### verif/dcsw_core_checker.sv
// Assertions on command selection and status word.
// Bound to dcsw_core, sees its ports only.
`timescale 1ns/1ps
module dcsw_core_checker (
	input	wire		clk,
	input	wire		sys_rst,
	input	wire [15:0]	netCmdWord,
	input	wire [15:0]	appCmdWord,
	input	wire [15:0]	keypadCmdWord,
	input	wire [1:0]	channelSel,
	input	wire		configMode,
	input	wire [15:0]	activeCmdWord,
	input	wire [15:0]	statusWord,
	input	wire [2:0]	seqState,
	input	wire		faultResetPulse,
	input	wire		runFlag,
	input	wire		jogFlag,
	input	wire		reverseFlag,
	input	wire		netRefFlag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Network source: selected outright, or handed over by application bit 10
	wire netSel = channelSel == 2'h0 || (channelSel != 2'h2 && appCmdWord[10]);
	// Bits 4-6 and 9 masked: their handling is left open
	property p_net_and; netSel |=> activeCmdWord[2:0] ==
		($past(netCmdWord[2:0]) & $past(appCmdWord[2:0])); endproperty
	a_net_and: assert property (p_net_and) else $error("net and");
	property p_net_or; netSel |=> activeCmdWord[8] ==
		($past(netCmdWord[8]) | $past(appCmdWord[8])); endproperty
	a_net_or: assert property (p_net_or) else $error("net or");
	property p_app; !netSel && channelSel != 2'h2 |=>
		(activeCmdWord & 16'hfd8f) == ($past(appCmdWord) & 16'hfd8f); endproperty
	a_app: assert property (p_app) else $error("app word");
	property p_kpd; channelSel == 2'h2 |=> (activeCmdWord & 16'hfd8f) ==
		(($past(keypadCmdWord) & 16'hfc88) | ($past(appCmdWord) & 16'h0107)); endproperty
	a_kpd: assert property (p_kpd) else $error("keypad word");
	property p_unused; statusWord[11:10] == 2'h0 && statusWord[8:7] == 2'h0; endproperty
	a_unused: assert property (p_unused) else $error("unused bits");
	property p_sod; !$past(sys_rst) |->
		statusWord[6] == ($past(seqState) == 3'h1); endproperty
	a_sod: assert property (p_sod) else $error("sod flag");
	property p_net; !$past(sys_rst) |->
		statusWord[9] == $past(netSel); endproperty
	a_net: assert property (p_net) else $error("net flag");
	property p_rdy; !$past(sys_rst) |->
		statusWord[0] == ($past(seqState) != 3'h0 && !$past(configMode)); endproperty
	a_rdy: assert property (p_rdy) else $error("ready flag");
	property p_frst; !$past(sys_rst) && !$past(sys_rst, 2) |-> faultResetPulse ==
		($past(activeCmdWord[7]) && !$past(activeCmdWord[7], 2)); endproperty
	a_frst: assert property (p_frst) else $error("reset pulse");
	property p_ext; activeCmdWord[8] && seqState >= 3'h1 && seqState <= 3'h5
		|=> seqState == 3'h6; endproperty
	a_ext: assert property (p_ext) else $error("ext trip");
	property p_leave; seqState == 3'h7 ##1 seqState != 3'h7 |-> seqState == 3'h1; endproperty
	a_leave: assert property (p_leave) else $error("fault exit");
	property p_flags; jogFlag == (activeCmdWord[3] && activeCmdWord[12]) &&
		reverseFlag == (activeCmdWord[3] && activeCmdWord[13]) &&
		netRefFlag == activeCmdWord[11]; endproperty
	a_flags: assert property (p_flags) else $error("jog reverse ref flags");
	property p_run; runFlag |-> seqState == 3'h4; endproperty
	a_run: assert property (p_run) else $error("run flag");
	property p_stsref; !$past(sys_rst) |-> statusWord[14:12] == {$past(activeCmdWord[11]),
		$past(activeCmdWord[13]), $past(activeCmdWord[12])}; endproperty
	a_stsref: assert property (p_stsref) else $error("jog reverse ref status");
	property p_stop; !$past(sys_rst) |-> statusWord[15] == ($past(seqState) == 3'h5 ||
		($past(seqState) == 3'h4 && !($past(activeCmdWord[3]) && $past(activeCmdWord[0]))));
		endproperty
	a_stop: assert property (p_stop) else $error("stopping flag");
	c_open: cover property (seqState == 3'h4);
	c_fault: cover property (seqState == 3'h7);
	c_pulse: cover property (faultResetPulse);
endmodule // dcsw_core_checker
bind dcsw_core dcsw_core_checker u_chk (.clk(clk), .sys_rst(sys_rst),
	.netCmdWord(netCmdWord), .appCmdWord(appCmdWord), .keypadCmdWord(keypadCmdWord),
	.channelSel(channelSel), .configMode(configMode), .activeCmdWord(activeCmdWord),
	.statusWord(statusWord), .seqState(seqState), .faultResetPulse(faultResetPulse),
	.runFlag(runFlag), .jogFlag(jogFlag), .reverseFlag(reverseFlag),
	.netRefFlag(netRefFlag));

// ### verif/dcsw_core_tb.sv
// Self-checking bench for dcsw_core.
// Assumes the controller model drives the network word.
`timescale 1ns/1ps
module dcsw_core_tb;
	reg		clk = 1'b0, sys_rst = 1'b1, initDone = 1'b0, configMode = 1'b0;
	reg		lineSupplyOk = 1'b1, faultActive = 1'b0, stopDone = 1'b1;
	reg [15:0]	app = 16'h0000, kpd = 16'h0000, req = 16'h0000;
	reg [1:0]	ch = 2'h1;
	wire [15:0]	net, acw, sw;
	wire [2:0]	st;
	reg [15:0]	q[$];
	integer		n_mismatch = 0, compares = 0, cyc = 0, i;
	dcsw_plc_model plc (.cmdReq(req), .netCmdWord(net));
	dcsw_core dut (.clk(clk), .sys_rst(sys_rst), .netCmdWord(net), .appCmdWord(app),
		.keypadCmdWord(kpd), .channelSel(ch), .initDone(initDone), .configMode(configMode),
		.lineSupplyOk(lineSupplyOk), .faultActive(faultActive), .stopDone(stopDone),
		.activeCmdWord(acw), .statusWord(sw), .seqState(st), .runFlag(), .jogFlag(),
		.reverseFlag(), .netRefFlag(), .faultResetPulse());
	initial forever #50 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_mismatch = n_mismatch + 1;
			end_of_test;
		end
	end
	function [15:0] expCmd(input [1:0] c, input [15:0] n, input [15:0] a, input [15:0] k);
		begin
			if (c == 2'h0 || (c != 2'h2 && a[10])) begin
				expCmd = {n[15:9], n[8] | a[8], n[7:3], n[2:0] & a[2:0]};
			end else if (c == 2'h2) begin
				expCmd = {k[15:9], a[8], k[7:3], a[2:0]};
			end else begin
				expCmd = a;
			end
		end
	endfunction
	// Settled status for an application-driven walk state
	function [15:0] expSt(input [2:0] e, input [15:0] w);
		expSt = {1'b0, w[11], w[13], w[12], 2'h0, 1'b0, 2'h0, e == 3'h1, e != 3'h5,
			lineSupplyOk, e >= 3'h6, e == 3'h4, e == 3'h3 || e == 3'h4, e != 3'h0};
	endfunction
	task fail(input [15:0] got, input [15:0] e);
		begin
			n_mismatch = n_mismatch + 1;
			$display("[FAIL] %0t got %h exp %h", $time, got, e);
		end
	endtask
	task chk_cmd(input [15:0] e);
		begin
			compares = compares + 1;
			if ((acw & 16'hfd8f) !== (e & 16'hfd8f)) fail(acw, e);
		end
	endtask
	task chk_st(input [2:0] e);
		begin
			compares = compares + 1;
			if (st !== e) fail({13'h0000, st}, {13'h0000, e});
		end
	endtask
	task chk_sw(input [15:0] e);
		begin
			compares = compares + 1;
			if (sw !== e) fail(sw, e);
		end
	endtask
	task step(input [15:0] w, input [2:0] e);
		begin
			app = w;
			repeat (6) @(negedge clk);
			chk_st(e);
			chk_sw(expSt(e, w));
		end
	endtask
	always @(posedge clk) begin
		if (q.size() > 0) begin
			#1;
			chk_cmd(q.pop_front());
		end
	end
	initial begin
		i = $urandom(32'he2110a0b);
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		initDone = 1'b1;
		for (i = 0; i < 200; i = i + 1) begin
			@(negedge clk);
			{ch, configMode, lineSupplyOk, faultActive, stopDone} = $urandom;
			{app, kpd} = $urandom;
			req = $urandom;
			q.push_back(expCmd(ch, req, app, kpd));
		end
		$display("test random_select done");
		@(negedge clk);
		// Second reset gives the walk a known start
		{sys_rst, ch, configMode, lineSupplyOk, faultActive, stopDone} = 7'h55;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		step(16'h0006, 3'h2);
		step(16'h0007, 3'h3);
		step(16'h000f, 3'h4);
		step(16'h000b, 3'h1);
		step(16'h0007, 3'h1);
		step(16'h4007, 3'h3);
		step(16'h0005, 3'h1);
		step(16'h8006, 3'h2);
		step(16'h800f, 3'h3);
		step(16'h8007, 3'h3);
		step(16'h800f, 3'h4);
		step(16'h8006, 3'h2);
		faultActive = 1'b1;
		step(16'h0086, 3'h7);
		faultActive = 1'b0;
		step(16'h0006, 3'h7);
		step(16'h0086, 3'h2);
		step(16'h0106, 3'h7);
		$display("test state_walk done");
		end_of_test;
	end
	task end_of_test;
		begin
			$display("compares %0d mismatches %0d", compares, n_mismatch);
			if (n_mismatch == 0 && compares > 0) begin
				$display("RESULT: PASS");
			end else begin
				$display("RESULT: FAIL");
			end
			$finish;
		end
	endtask
endmodule // dcsw_core_tb
